// ==== standby_pkg.sv ====
// Constants and types shared by the standby controller and its settle counter
package standby_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] OSC_SETTLE_STATUS_ADDR = 16'hffa3;
    localparam logic [15:0] OSC_SETTLE_SELECT_ADDR = 16'hffa4;
    localparam logic [7:0]  OSC_SETTLE_STATUS_RST  = 8'h00;
    localparam logic [2:0]  OSC_SETTLE_SELECT_RST  = 3'h5;
    localparam int          SELECT_W               = 3;
    localparam int          STATUS_W               = 5;

    // ****************************************************************
    // Select codes and thresholds
    // ****************************************************************
    localparam logic [2:0] SEL_2P11 = 3'h1;
    localparam logic [2:0] SEL_2P13 = 3'h2;
    localparam logic [2:0] SEL_2P14 = 3'h3;
    localparam logic [2:0] SEL_2P15 = 3'h4;
    localparam logic [2:0] SEL_2P16 = 3'h5;
    localparam int         COUNT_W  = 17;
    // Crystal periods at which each status bit sets
    localparam logic [16:0] COUNT_2P11 = 17'h0_0800;
    localparam logic [16:0] COUNT_2P13 = 17'h0_2000;
    localparam logic [16:0] COUNT_2P14 = 17'h0_4000;
    localparam logic [16:0] COUNT_2P15 = 17'h0_8000;
    localparam logic [16:0] COUNT_2P16 = 17'h1_0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int         RING_WAIT_PERIODS = 17;
    localparam logic [4:0] RING_WAIT_TICKS   = 5'(RING_WAIT_PERIODS);

    // ****************************************************************
    // Standby state
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_RUN       = 5'b00001,
        ST_HALT      = 5'b00010,
        ST_STOP      = 5'b00100,
        ST_WAIT_RING = 5'b01000,
        ST_WAIT_XTAL = 5'b10000
    } standby_state_e;

endpackage : standby_pkg

// ==== settle_if.sv ====
// Link between the standby controller and the stabilisation counter
interface settle_if;
    logic       clear;
    logic       xtal_tick;
    logic       count_ok;
    logic [2:0] select;
    logic [4:0] status;
    logic       done;

    modport ctl (output clear, output xtal_tick, output count_ok, output select, input status, input done);
    modport cnt (input clear, input xtal_tick, input count_ok, input select, output status, output done);
endinterface : settle_if

// ==== settle_counter.sv ====
// Crystal stabilisation counter with thermometer status bits
module settle_counter
(
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    settle_if.cnt     link
);

    typedef struct packed {
        logic [16:0] count;
        logic [4:0]  status;
    } cnt_state_s;

    cnt_state_s st;
    cnt_state_s next_st;
    logic [4:0] reached;

    // ****************************************************************
    // Threshold compare, bit 4 is the lowest threshold
    // ****************************************************************
    always_comb
    begin
        reached[4] = st.count >= standby_pkg::COUNT_2P11;
        reached[3] = st.count >= standby_pkg::COUNT_2P13;
        reached[2] = st.count >= standby_pkg::COUNT_2P14;
        reached[1] = st.count >= standby_pkg::COUNT_2P15;
        reached[0] = st.count >= standby_pkg::COUNT_2P16;
    end

    // Done when the status bit of the selected code is up
    always_comb
    begin
        case (link.select)
            standby_pkg::SEL_2P11: link.done = st.status[4];
            standby_pkg::SEL_2P13: link.done = st.status[3];
            standby_pkg::SEL_2P14: link.done = st.status[2];
            standby_pkg::SEL_2P15: link.done = st.status[1];
            default:               link.done = st.status[0];
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        if (link.clear)
        begin
            next_st = '0;
        end
        else
        begin
            // Counting halts at the selected time, so later bits stay low
            if (link.count_ok && link.xtal_tick && !link.done)
            begin
                next_st.count = st.count + 17'h0_0001;
            end
            next_st.status = st.status | reached;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign link.status = st.status;

endmodule : settle_counter

// ==== standby_ctrl.sv ====
// Standby controller: HALT and STOP modes, clock gating and settle registers
module standby_ctrl
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       halt_exec_in,
    input  wire logic       stop_exec_in,
    input  wire logic       irq_in,
    input  wire logic       cpu_on_ring_in,
    input  wire logic       main_osc_stop_bit_in,
    input  wire logic       main_osc_stop_set_in,
    input  wire logic       cpu_clock_select_set_in,
    input  wire logic       internal_ring_oscillator_stop_bit_in,
    input  wire logic       ring_stop_option_in,
    input  wire logic       xtal_tick_in,
    input  wire logic       xtal_running_in,
    input  wire logic       ring_tick_in,
    input  wire logic [15:0] addr_in,
    input  wire logic       rd_in,
    input  wire logic       wr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    output logic            cpu_clk_enable_out,
    output logic            state_hold_out,
    output logic            main_osc_enable_out,
    output logic            internal_ring_oscillator_enable_out,
    output logic            sub_osc_enable_out,
    output logic            halt_mode_out,
    output logic            stop_mode_out
);

    typedef struct packed {
        standby_pkg::standby_state_e mode;
        logic [2:0]                  select;
        logic [4:0]                  ring_cnt;
        logic [7:0]                  rdata;
    } ctrl_state_s;

    ctrl_state_s st;
    ctrl_state_s next_st;
    logic [1:0]  rst_sync;
    logic        rst_b;
    logic        sel_legal;

    settle_if sif ();

    // ****************************************************************
    // Reset release, held low two edges after the pin rises
    // ****************************************************************
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_sync <= 2'b00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_b = rst_sync[1];

    // ****************************************************************
    // Counter hookup
    // ****************************************************************
    // Clear on any stop or clock-source change; reset clears it too
    assign sif.clear     = stop_exec_in || main_osc_stop_set_in || cpu_clock_select_set_in;
    assign sif.xtal_tick = xtal_tick_in;
    // Count only while the crystal really oscillates
    assign sif.count_ok  = xtal_running_in && !main_osc_stop_bit_in && (st.mode != standby_pkg::ST_STOP);
    assign sif.select    = st.select;

    settle_counter u_settle_counter
    (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b),
        .link       (sif.cnt)
    );

    // Prohibited codes are ignored so the wait never goes undefined
    always_comb
    begin
        case (wdata_in[2:0])
            standby_pkg::SEL_2P11,
            standby_pkg::SEL_2P13,
            standby_pkg::SEL_2P14,
            standby_pkg::SEL_2P15,
            standby_pkg::SEL_2P16: sel_legal = 1'b1;
            default:               sel_legal = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state: mode sequencing and register access
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        case (st.mode)
            standby_pkg::ST_RUN:
            begin
                if (stop_exec_in)
                begin
                    next_st.mode = standby_pkg::ST_STOP;
                end
                else if (halt_exec_in)
                begin
                    next_st.mode = standby_pkg::ST_HALT;
                end
            end
            standby_pkg::ST_HALT:
            begin
                if (irq_in)
                begin
                    next_st.mode = standby_pkg::ST_RUN;
                end
            end
            standby_pkg::ST_STOP:
            begin
                next_st.ring_cnt = '0;
                if (irq_in)
                begin
                    // Ring clock skips the crystal wait entirely
                    if (cpu_on_ring_in)
                    begin
                        next_st.mode = standby_pkg::ST_WAIT_RING;
                    end
                    else
                    begin
                        next_st.mode = standby_pkg::ST_WAIT_XTAL;
                    end
                end
            end
            standby_pkg::ST_WAIT_RING:
            begin
                if (ring_tick_in)
                begin
                    next_st.ring_cnt = st.ring_cnt + 5'h01;
                    if (st.ring_cnt == standby_pkg::RING_WAIT_TICKS - 5'h01)
                    begin
                        next_st.mode = standby_pkg::ST_RUN;
                    end
                end
            end
            standby_pkg::ST_WAIT_XTAL:
            begin
                if (sif.done)
                begin
                    next_st.mode = standby_pkg::ST_RUN;
                end
            end
            default:
            begin
                next_st.mode = standby_pkg::ST_RUN;
            end
        endcase

        // Select register write; status register ignores writes
        if (wr_in && addr_in == standby_pkg::OSC_SETTLE_SELECT_ADDR && sel_legal)
        begin
            next_st.select = wdata_in[2:0];
        end

        // Byte read; a bit read picks its bit from the same byte
        if (rd_in)
        begin
            if (addr_in == standby_pkg::OSC_SETTLE_STATUS_ADDR)
            begin
                next_st.rdata = {3'b000, sif.status};
            end
            else if (addr_in == standby_pkg::OSC_SETTLE_SELECT_ADDR)
            begin
                next_st.rdata = {5'b00000, st.select};
            end
            else
            begin
                next_st.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st.mode     <= standby_pkg::ST_RUN;
            st.select   <= standby_pkg::OSC_SETTLE_SELECT_RST;
            st.ring_cnt <= '0;
            st.rdata    <= standby_pkg::OSC_SETTLE_STATUS_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata_out           = st.rdata;
    assign halt_mode_out       = st.mode == standby_pkg::ST_HALT;
    assign stop_mode_out       = st.mode == standby_pkg::ST_STOP;
    // CPU clock only in normal run
    assign cpu_clk_enable_out  = st.mode == standby_pkg::ST_RUN;
    // Everything the CPU owns freezes while its clock is gated
    assign state_hold_out      = st.mode != standby_pkg::ST_RUN;
    // Crystal stops in STOP whatever the CPU clock source
    assign main_osc_enable_out = !main_osc_stop_bit_in && !stop_mode_out;
    // Ring keeps running in HALT and STOP; software stop needs the option
    // Never stopped while it clocks the CPU in standby, or the ring wait would hang
    assign internal_ring_oscillator_enable_out = !(internal_ring_oscillator_stop_bit_in && ring_stop_option_in)
                                 || (cpu_on_ring_in && state_hold_out);
    // Subsystem oscillator is never stopped by standby itself
    assign sub_osc_enable_out  = 1'b1;

endmodule : standby_ctrl

// ==== standby_sva.sv ====
// Checker for the standby controller's port behaviour
module standby_sva
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic halt_exec_in,
    input wire logic stop_exec_in,
    input wire logic irq_in,
    input wire logic cpu_on_ring_in,
    input wire logic main_osc_stop_bit_in,
    input wire logic internal_ring_oscillator_stop_bit_in,
    input wire logic ring_stop_option_in,
    input wire logic xtal_tick_in,
    input wire logic xtal_running_in,
    input wire logic ring_tick_in,
    input wire logic cpu_clk_enable_out,
    input wire logic state_hold_out,
    input wire logic main_osc_enable_out,
    input wire logic internal_ring_oscillator_enable_out,
    input wire logic halt_mode_out,
    input wire logic stop_mode_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [4:0]  ring_cnt;
    logic [11:0] xtal_cnt;
    logic        woke;
    wire         run = cpu_clk_enable_out && !state_hold_out;
    // Good ticks since STOP ended; saturating so long runs stay bounded
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ring_cnt <= 5'h00;
            xtal_cnt <= 12'h000;
            woke     <= 1'h0;
        end
        else
        begin
            woke     <= stop_mode_out || (woke && !cpu_clk_enable_out);
            ring_cnt <= stop_mode_out ? 5'h00 : ring_cnt + 5'(ring_tick_in && ring_cnt != 5'h1f);
            xtal_cnt <= stop_mode_out ? 12'h000 : xtal_cnt + 12'(xtal_tick_in && xtal_running_in && xtal_cnt != 12'hfff);
        end
    end
    // Wake from STOP: leaves STOP, clock still withheld
    sequence s_release;
        stop_mode_out && irq_in ##1 !stop_mode_out;
    endsequence
    a_halt_entry: assert property (run && halt_exec_in && !stop_exec_in |=> halt_mode_out)
        else $error("halt request did not enter halt");
    a_halt_wake: assert property (halt_mode_out && irq_in |=> !halt_mode_out)
        else $error("halt not left on interrupt");
    a_stop_entry: assert property (run && stop_exec_in |=> stop_mode_out && !main_osc_enable_out)
        else $error("stop request did not stop crystal");
    a_halt_osc_run: assert property (halt_mode_out && !main_osc_stop_bit_in |-> main_osc_enable_out && (internal_ring_oscillator_enable_out || (internal_ring_oscillator_stop_bit_in && ring_stop_option_in)))
        else $error("oscillator stopped in halt");
    a_ring_keep: assert property ((stop_mode_out && cpu_on_ring_in) || !ring_stop_option_in |-> internal_ring_oscillator_enable_out)
        else $error("ring oscillator stopped");
    a_standby_hold: assert property (halt_mode_out || stop_mode_out |-> state_hold_out && !cpu_clk_enable_out)
        else $error("standby without hold");
    a_stop_wake: assert property (s_release |-> !cpu_clk_enable_out && state_hold_out)
        else $error("clock resumed without wait");
    a_ring_stall: assert property ($rose(cpu_clk_enable_out) && woke && cpu_on_ring_in |-> ring_cnt >= 5'h11)
        else $error("ring wait too short");
    a_ring_resume: assert property (woke && cpu_on_ring_in && ring_cnt == 5'h11 |-> ##[0:2] cpu_clk_enable_out)
        else $error("ring wait too long");
    a_xtal_wait: assert property ($rose(cpu_clk_enable_out) && woke && !cpu_on_ring_in |-> xtal_cnt >= 12'h800)
        else $error("crystal wait too short");
endmodule : standby_sva

// ==== osc_model.sv ====
// Behavioural crystal and ring oscillators at the block's far side
module osc_model
#(
    parameter int START_CYCLES = 20,
    parameter int RING_DIV     = 3
)
(
    input  wire logic sys_clk_in,
    input  wire logic rst_b_in,
    input  wire logic main_osc_enable_in,
    input  wire logic internal_ring_oscillator_enable_in,
    output logic      xtal_tick_out,
    output logic      xtal_running_out,
    output logic      ring_tick_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int start;
    int div;
    // Start-up count and ring divider; crystal edges come before it is stable
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            start <= 0;
            div   <= 0;
        end
        else
        begin
            start <= main_osc_enable_in ? ((start < START_CYCLES) ? start + 1 : start) : 0;
            div   <= (internal_ring_oscillator_enable_in && div < RING_DIV - 1) ? div + 1 : 0;
        end
    end
    // Unstable edges must not count toward the wait
    assign xtal_tick_out    = main_osc_enable_in;
    assign xtal_running_out = main_osc_enable_in && start >= START_CYCLES;
    assign ring_tick_out    = internal_ring_oscillator_enable_in && div == RING_DIV - 1;
endmodule : osc_model

// ==== tb.sv ====
// Register and standby scenarios for the standby controller
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_b = 1'h0, halt_exec = 1'h0, stop_exec = 1'h0, irq = 1'h0, on_ring = 1'h0;
    logic osc_stop_bit = 1'h0, osc_stop_set = 1'h0, clk_sel_set = 1'h0, ring_stop = 1'h0, ring_opt = 1'h0;
    logic rd = 1'h0, wr = 1'h0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00, rdata, got, prev;
    logic cpu_en, hold, mosc_en, ring_en, sub_en, halt_m, stop_m, xtal_tick, xtal_run, ring_tick;
    int fail_count = 0;
    int cmp_count = 0;
    logic [7:0] bad [3] = '{8'h00, 8'h06, 8'h07};
    always #2 clk = ~clk;
    standby_ctrl u_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .halt_exec_in(halt_exec), .stop_exec_in(stop_exec),
        .irq_in(irq), .cpu_on_ring_in(on_ring), .main_osc_stop_bit_in(osc_stop_bit), .main_osc_stop_set_in(osc_stop_set),
        .cpu_clock_select_set_in(clk_sel_set), .internal_ring_oscillator_stop_bit_in(ring_stop), .ring_stop_option_in(ring_opt),
        .xtal_tick_in(xtal_tick), .xtal_running_in(xtal_run), .ring_tick_in(ring_tick), .addr_in(addr), .rd_in(rd),
        .wr_in(wr), .wdata_in(wdata), .rdata_out(rdata), .cpu_clk_enable_out(cpu_en), .state_hold_out(hold),
        .main_osc_enable_out(mosc_en), .internal_ring_oscillator_enable_out(ring_en), .sub_osc_enable_out(sub_en),
        .halt_mode_out(halt_m), .stop_mode_out(stop_m));
    osc_model u_osc (.sys_clk_in(clk), .rst_b_in(rst_b), .main_osc_enable_in(mosc_en), .internal_ring_oscillator_enable_in(ring_en),
        .xtal_tick_out(xtal_tick), .xtal_running_out(xtal_run), .ring_tick_out(ring_tick));
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic conclude();
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : reg_write
    // Read data is registered at the taking edge and stands until the next read
    task automatic reg_read(input logic [15:0] a, output logic [7:0] g);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 g = rdata;
    endtask : reg_read
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] g;
        reg_read(a, g);
        check(g, e);
    endtask : rd_chk
    // One-cycle strobe: 0 halt, 1 stop, 2 crystal-stop set, 3 clock-select set, 4 wake
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: halt_exec <= 1'h1;
            1: stop_exec <= 1'h1;
            2: osc_stop_set <= 1'h1;
            3: clk_sel_set <= 1'h1;
            default: irq <= 1'h1;
        endcase
        @(posedge clk);
        {halt_exec, stop_exec, osc_stop_set, clk_sel_set, irq} <= 5'h00;
        #1;
    endtask : pulse
    // Bounded wait for the CPU clock to come back
    task automatic wait_clk(input int n);
        for (int i = 0; i < n && cpu_en !== 1'h1; i++)
            @(posedge clk) #1;
        check({7'h00, cpu_en}, 8'h01);
    endtask : wait_clk
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        rd_chk(16'hffa3, 8'h00);
        rd_chk(16'hffa4, 8'h05);
        rd_chk(16'hffa5, 8'h00);
        reg_write(16'hffa3, 8'hff);
        rd_chk(16'hffa3, 8'h00);
        foreach (bad[i])
        begin
            reg_write(16'hffa4, bad[i]);
            rd_chk(16'hffa4, 8'h05);
        end
        for (int k = 1; k <= 5; k++)
        begin
            reg_write(16'hffa4, 8'(k));
            rd_chk(16'hffa4, 8'(k));
        end
        pulse(0);
        check({7'h00, halt_m}, 8'h01);
        check({4'h0, hold, sub_en, ring_en, mosc_en}, 8'h0f);
        pulse(4);
        check({6'h00, halt_m, cpu_en}, 8'h01);
        reg_write(16'hffa4, 8'h01);
        // The bench runs no peripherals, so stop may follow at once
        pulse(1);
        check({6'h00, mosc_en, hold}, 8'h01);
        rd_chk(16'hffa3, 8'h00);
        pulse(4);
        wait_clk(3000);
        rd_chk(16'hffa3, 8'h10);
        repeat (6200) @(posedge clk);
        rd_chk(16'hffa3, 8'h10);
        // Crystal held stopped: status clears and nothing is counted
        osc_stop_bit <= 1'h1;
        pulse(2);
        check({7'h00, mosc_en}, 8'h00);
        rd_chk(16'hffa3, 8'h00);
        repeat (2100) @(posedge clk);
        rd_chk(16'hffa3, 8'h00);
        osc_stop_bit <= 1'h0;
        repeat (2100) @(posedge clk);
        rd_chk(16'hffa3, 8'h10);
        pulse(3);
        rd_chk(16'hffa3, 8'h00);
        on_ring <= 1'h1;
        reg_write(16'hffa4, 8'h03);
        pulse(1);
        check({6'h00, ring_en, mosc_en}, 8'h02);
        pulse(4);
        wait_clk(200);
        prev = 8'h00;
        for (int i = 0; i < 80 && prev !== 8'h1c; i++)
        begin
            repeat (256) @(posedge clk);
            reg_read(16'hffa3, got);
            check({7'h00, (got inside {8'h00, 8'h10, 8'h18, 8'h1c}) && got >= prev}, 8'h01);
            prev = got;
        end
        rd_chk(16'hffa3, 8'h1c);
        // Mid-run reset clears the status and restores the longest wait
        rst_b <= 1'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk);
        rd_chk(16'hffa3, 8'h00);
        rd_chk(16'hffa4, 8'h05);
        on_ring <= 1'h0;
        ring_stop <= 1'h1;
        repeat (2) @(posedge clk) #1;
        check({7'h00, ring_en}, 8'h01);
        ring_opt <= 1'h1;
        repeat (2) @(posedge clk) #1;
        check({7'h00, ring_en}, 8'h00);
        conclude();
    end
    // Watchdog well beyond the expected run
    initial
    begin
        #240000;
        fail_count++;
        conclude();
    end
endmodule : tb
bind standby_ctrl standby_sva u_sva (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .halt_exec_in(halt_exec_in),
    .stop_exec_in(stop_exec_in), .irq_in(irq_in), .cpu_on_ring_in(cpu_on_ring_in),
    .main_osc_stop_bit_in(main_osc_stop_bit_in), .internal_ring_oscillator_stop_bit_in(internal_ring_oscillator_stop_bit_in),
    .ring_stop_option_in(ring_stop_option_in), .xtal_tick_in(xtal_tick_in), .xtal_running_in(xtal_running_in),
    .ring_tick_in(ring_tick_in), .cpu_clk_enable_out(cpu_clk_enable_out), .state_hold_out(state_hold_out),
    .main_osc_enable_out(main_osc_enable_out), .internal_ring_oscillator_enable_out(internal_ring_oscillator_enable_out),
    .halt_mode_out(halt_mode_out), .stop_mode_out(stop_mode_out));
